// *** core/eewa_pkg.sv ***
// Purpose: Shared constants for the word-access EEPROM controller
// Assumes: 125 MHz system clock, AHB-Lite register access
// Notes: Register map is a 256-byte window, one register per word

package eewa_pkg;

    // Clock and operation timing
    localparam int unsigned SYS_CLK_MHZ = 125;
    localparam int unsigned PROG_TIME_NS = 1000;
    localparam int unsigned ERASE_TIME_NS = 8000;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int unsigned ERASE_CYCLES = (ERASE_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] PROG_CNT = CNT_W'(PROG_CYCLES);
    localparam logic [CNT_W-1:0] ERASE_CNT = CNT_W'(ERASE_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;

    // Array geometry
    localparam int WORDS = 64;
    localparam int IDX_W = 6;
    localparam logic [31:0] SIZE_BYTES = 32'h0000_0100;
    localparam logic [31:0] ERASED_WORD = 32'hffff_ffff;
    localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

    // Register byte offsets
    localparam logic [7:0] OFS_ADDR = 8'h00;
    localparam logic [7:0] OFS_WDATA = 8'h04;
    localparam logic [7:0] OFS_RDATA = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_SIZE = 8'h14;
    localparam logic [7:0] OFS_PROT = 8'h18;
    localparam logic [7:0] OFS_RIS = 8'h1c;
    localparam logic [7:0] OFS_IM = 8'h20;
    localparam logic [7:0] OFS_MIS = 8'h24;
    localparam logic [7:0] OFS_ICR = 8'h28;
    localparam logic [7:0] OFS_FLASH_IM = 8'h2c;

    // Field positions and reset values
    localparam int ST_INVPL = 0;
    localparam int ST_WRBUSY = 1;
    localparam int ST_NOPERM = 2;
    localparam int ST_COPY = 3;
    localparam int ST_ERASE = 4;
    localparam int ST_WORKING = 5;
    localparam int INT_PROGRAM_BIT = 0;
    localparam int FIM_EEPROM_BIT = 2;
    localparam int CMD_ERASE_BIT = 0;
    localparam int PROT_WP_BIT = 0;
    localparam int PROT_SUP_BIT = 1;
    localparam logic [1:0] PROT_RESET = 2'h0;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} eewa_op_type;

endpackage

// *** core/eewa_op_timer.sv ***
// Purpose: Counts out the duration of a program or erase operation
// Assumes: start only while idle
// Notes: done is a one-cycle pulse on the last counted cycle

`timescale 1ns/1ns
`default_nettype none

module eewa_op_timer (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic start,
    input wire logic erase,
    output logic busy,
    output logic done
);

    logic [eewa_pkg::CNT_W-1:0] cnt_reg;
    logic [eewa_pkg::CNT_W-1:0] cnt_next;

    assign busy = cnt_reg != eewa_pkg::CNT_ZERO;
    assign done = cnt_reg == eewa_pkg::CNT_ONE;
    assign cnt_next = start ? (erase ? eewa_pkg::ERASE_CNT : eewa_pkg::PROG_CNT)
                    : busy ? cnt_reg - eewa_pkg::CNT_ONE : eewa_pkg::CNT_ZERO;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            cnt_reg <= eewa_pkg::CNT_ZERO;
        else
            cnt_reg <= cnt_next;
    end

endmodule

`default_nettype wire

// *** core/eewa_int_ctrl.sv ***
// Purpose: Completion interrupt, raw flag with enable and clear
// Assumes: set and clear are one-cycle pulses
// Notes: A set in the clearing cycle wins

`timescale 1ns/1ns
`default_nettype none

module eewa_int_ctrl (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic set_evt,
    input wire logic clr,
    input wire logic en_we,
    input wire logic en_d,
    output logic raw,
    output logic masked,
    output logic en
);

    logic raw_reg;
    logic en_reg;

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            raw_reg <= 1'b0;
        else if (set_evt)
            raw_reg <= 1'b1;
        else if (clr)
            raw_reg <= 1'b0;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            en_reg <= 1'b0;
        else if (en_we)
            en_reg <= en_d;
    end

    assign raw = raw_reg;
    assign en = en_reg;
    assign masked = raw_reg & en_reg;

endmodule

`default_nettype wire

// *** core/eewa_ctrl.sv ***
// Purpose: Word-organised EEPROM controller with AHB-Lite registers
// Assumes: Single AHB-Lite slave, whole-word transfers only
// Notes: Reads take one wait state, writes none; hresp is always OKAY
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.

`timescale 1ns/1ns
`default_nettype none

module eewa_ctrl (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [3:0] hprot,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic flash_irq_in,
    output logic shared_irq
);

    function automatic logic hit(input logic [5:0] idx, input logic [7:0] ofs);
        return idx == ofs[7:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic dp_wr_reg;
    logic dp_rd_reg;
    logic rd_wait_reg;
    logic [5:0] dp_idx_reg;
    logic dp_priv_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] rd_mux;
    wire logic addr_take = hsel & htrans[1] & hready;
    wire logic rd_fire = dp_rd_reg & ~rd_wait_reg;
    wire logic wr_fire = dp_wr_reg;

    // Data phase state follows each address phase that the bus completes
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            dp_wr_reg <= 1'b0;
        else if (hready)
            dp_wr_reg <= addr_take & hwrite;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            dp_rd_reg <= 1'b0;
        else if (hready)
            dp_rd_reg <= addr_take & ~hwrite;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            dp_idx_reg <= 6'h00;
        else if (hready)
            dp_idx_reg <= haddr[7:2];
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            dp_priv_reg <= 1'b0;
        else if (hready)
            dp_priv_reg <= hprot[1];
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            rd_wait_reg <= 1'b0;
        else
            rd_wait_reg <= rd_fire;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            hrdata_reg <= 32'h0000_0000;
        else if (rd_fire)
            hrdata_reg <= rd_mux;
    end

    assign hreadyout = ~rd_fire;
    assign hrdata = hrdata_reg;
    assign hresp = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Decode

    // Register selected by the current data phase
    wire logic sel_addr = hit(dp_idx_reg, eewa_pkg::OFS_ADDR);
    wire logic sel_wdata = hit(dp_idx_reg, eewa_pkg::OFS_WDATA);
    wire logic sel_rdata = hit(dp_idx_reg, eewa_pkg::OFS_RDATA);
    wire logic sel_cmd = hit(dp_idx_reg, eewa_pkg::OFS_CMD);
    wire logic sel_status = hit(dp_idx_reg, eewa_pkg::OFS_STATUS);
    wire logic sel_size = hit(dp_idx_reg, eewa_pkg::OFS_SIZE);
    wire logic sel_prot = hit(dp_idx_reg, eewa_pkg::OFS_PROT);
    wire logic sel_ris = hit(dp_idx_reg, eewa_pkg::OFS_RIS);
    wire logic sel_im = hit(dp_idx_reg, eewa_pkg::OFS_IM);
    wire logic sel_mis = hit(dp_idx_reg, eewa_pkg::OFS_MIS);
    wire logic sel_icr = hit(dp_idx_reg, eewa_pkg::OFS_ICR);
    wire logic sel_fim = hit(dp_idx_reg, eewa_pkg::OFS_FLASH_IM);

    wire logic wr_addr = wr_fire & sel_addr;
    wire logic wr_wdata = wr_fire & sel_wdata;
    wire logic wr_cmd = wr_fire & sel_cmd;
    wire logic wr_prot = wr_fire & sel_prot;
    wire logic wr_im = wr_fire & sel_im;
    wire logic wr_icr = wr_fire & sel_icr;
    wire logic wr_fim = wr_fire & sel_fim;
    wire logic rd_rdata = rd_fire & sel_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Operation control

    eewa_pkg::eewa_op_type op_state_reg;
    eewa_pkg::eewa_op_type op_state_next;
    logic [31:0] addr_reg;
    logic [1:0] prot_reg;
    logic [eewa_pkg::IDX_W-1:0] prog_idx_reg;
    logic [31:0] prog_data_reg;
    logic invalid_param_flag;
    logic write_busy_flag;
    logic no_permission_flag;
    logic [31:0] mem_reg [eewa_pkg::WORDS];
    logic tmr_done;

    wire logic busy = op_state_reg != eewa_pkg::OP_IDLE;
    wire logic addr_aligned = addr_reg[1:0] == 2'h0;
    wire logic addr_in_range = addr_reg[31:eewa_pkg::IDX_W+2] == '0;
    wire logic param_ok = addr_aligned & addr_in_range;
    wire logic perm_rd_ok = ~prot_reg[eewa_pkg::PROT_SUP_BIT] | dp_priv_reg;
    wire logic perm_wr_ok = perm_rd_ok & ~prot_reg[eewa_pkg::PROT_WP_BIT];
    wire logic prog_req = wr_wdata;
    wire logic erase_req = wr_cmd & hwdata[eewa_pkg::CMD_ERASE_BIT];
    wire logic req_any = prog_req | erase_req;
    wire logic prog_go = prog_req & ~busy & param_ok & perm_wr_ok;
    wire logic erase_go = erase_req & ~busy;
    wire logic rd_ok = rd_rdata & param_ok & perm_rd_ok;
    wire logic [eewa_pkg::IDX_W-1:0] addr_idx = addr_reg[eewa_pkg::IDX_W+1:2];
    wire logic prog_done = tmr_done & (op_state_reg == eewa_pkg::OP_PROG);
    wire logic erase_done = tmr_done & (op_state_reg == eewa_pkg::OP_ERASE);

    eewa_op_timer u_timer (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(prog_go | erase_go),
        .erase(erase_go),
        .busy(),
        .done(tmr_done)
    );

    always_comb
    begin
        op_state_next = op_state_reg;
        unique case (op_state_reg)
            eewa_pkg::OP_IDLE:
            begin
                if (prog_go)
                    op_state_next = eewa_pkg::OP_PROG;
                else if (erase_go)
                    op_state_next = eewa_pkg::OP_ERASE;
            end
            eewa_pkg::OP_PROG, eewa_pkg::OP_ERASE:
            begin
                if (tmr_done)
                    op_state_next = eewa_pkg::OP_IDLE;
            end
            default:
                op_state_next = eewa_pkg::OP_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            op_state_reg <= eewa_pkg::OP_IDLE;
        else
            op_state_reg <= op_state_next;
    end

    // Error flags describe the latest program or erase request
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            invalid_param_flag <= 1'b0;
        else if (req_any)
            invalid_param_flag <= prog_req & ~param_ok;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            write_busy_flag <= 1'b0;
        else if (req_any)
            write_busy_flag <= busy;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            no_permission_flag <= 1'b0;
        else if (req_any)
            no_permission_flag <= prog_req & ~perm_wr_ok;
    end

    // Word pointer steps after each accepted word
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            addr_reg <= eewa_pkg::ADDR_RESET;
        else if (wr_addr)
            addr_reg <= hwdata;
        else if (prog_go | rd_ok)
            addr_reg <= addr_reg + eewa_pkg::ADDR_STEP;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            prog_idx_reg <= '0;
        else if (prog_go)
            prog_idx_reg <= addr_idx;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            prog_data_reg <= 32'h0000_0000;
        else if (prog_go)
            prog_data_reg <= hwdata;
    end

    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            prot_reg <= eewa_pkg::PROT_RESET;
        else if (erase_done)
            prot_reg <= eewa_pkg::PROT_RESET;
        else if (wr_prot & ~busy)
            prot_reg <= hwdata[1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array

    genvar gi;
    generate
        for (gi = 0; gi < eewa_pkg::WORDS; gi++)
        begin : g_word
            always_ff @(posedge sys_clk or negedge nrst)
            begin
                if (!nrst)
                    mem_reg[gi] <= eewa_pkg::ERASED_WORD;
                else if (erase_done)
                    mem_reg[gi] <= eewa_pkg::ERASED_WORD;
                else if (prog_done && prog_idx_reg == eewa_pkg::IDX_W'(gi))
                    mem_reg[gi] <= prog_data_reg;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt

    logic int_raw;
    logic int_masked;
    logic int_en;
    wire logic en_we = wr_im | wr_fim;
    wire logic en_d = wr_fim ? hwdata[eewa_pkg::FIM_EEPROM_BIT]
                             : hwdata[eewa_pkg::INT_PROGRAM_BIT];

    eewa_int_ctrl u_int (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .set_evt(tmr_done),
        .clr(wr_icr & hwdata[eewa_pkg::INT_PROGRAM_BIT]),
        .en_we(en_we),
        .en_d(en_d),
        .raw(int_raw),
        .masked(int_masked),
        .en(int_en)
    );

    assign shared_irq = flash_irq_in | int_masked;

    ////////////////////////////////////////////////////////////////////////////
    // Read data

    wire logic [31:0] status_word =
        (32'(invalid_param_flag) << eewa_pkg::ST_INVPL)
        | (32'(write_busy_flag) << eewa_pkg::ST_WRBUSY)
        | (32'(no_permission_flag) << eewa_pkg::ST_NOPERM)
        | (32'(op_state_reg == eewa_pkg::OP_PROG) << eewa_pkg::ST_COPY)
        | (32'(op_state_reg == eewa_pkg::OP_ERASE) << eewa_pkg::ST_ERASE)
        | (32'(busy) << eewa_pkg::ST_WORKING);
    wire logic [31:0] ris_word = 32'(int_raw) << eewa_pkg::INT_PROGRAM_BIT;
    wire logic [31:0] mis_word = 32'(int_masked) << eewa_pkg::INT_PROGRAM_BIT;
    wire logic [31:0] im_word = 32'(int_en) << eewa_pkg::INT_PROGRAM_BIT;
    wire logic [31:0] fim_word = 32'(int_en) << eewa_pkg::FIM_EEPROM_BIT;
    wire logic [31:0] mem_word = rd_ok ? mem_reg[addr_idx] : 32'h0000_0000;

    assign rd_mux =
        sel_addr ? addr_reg
        : sel_rdata ? mem_word
        : sel_status ? status_word
        : sel_size ? eewa_pkg::SIZE_BYTES
        : sel_prot ? {30'h0, prot_reg}
        : sel_ris ? ris_word
        : sel_im ? im_word
        : sel_mis ? mis_word
        : sel_fim ? fim_word
        : 32'h0000_0000;

endmodule

`default_nettype wire

// *** bench/eewa_ctrl_properties.sv ***
// Purpose: Port properties of the EEPROM controller
// Assumes: One clock, nrst async active low
// Notes: Bound to eewa_ctrl after the module
`timescale 1ns/1ns
`default_nettype none
module eewa_ctrl_properties (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic flash_irq_in,
    input wire logic shared_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    wire logic take = hsel & htrans[1] & hready;
    wire logic rd = take & !hwrite;
    wire logic [7:0] ofs = haddr[7:0];
    logic wph;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            wph <= 1'b0;
        else
            wph <= take & hwrite;
    end
    a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
    a_read_wait: assert property (rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    a_write_nowait: assert property (take & hwrite |=> hreadyout)
        else $error("write wait state");
    a_size_value: assert property (rd && ofs == eewa_pkg::OFS_SIZE |=>
        ##1 hrdata == eewa_pkg::SIZE_BYTES) else $error("size wrong");
    a_int_onebit: assert property (rd && (ofs == eewa_pkg::OFS_RIS ||
        ofs == eewa_pkg::OFS_MIS) |=> ##1 hrdata[31:1] == 31'h0) else $error("int bits");
    a_status_bits: assert property (rd && ofs == eewa_pkg::OFS_STATUS |=>
        ##1 hrdata[31:6] == 26'h0) else $error("status bits");
    a_mis_match: assert property (rd && ofs == eewa_pkg::OFS_MIS ##1 !flash_irq_in
        |=> hrdata[0] == $past(shared_irq)) else $error("masked state differs");
    a_flash_or: assert property (flash_irq_in |-> shared_irq)
        else $error("flash irq lost");
    a_irq_steady: assert property ($fell(shared_irq) && !$past(flash_irq_in)
        |-> $past(wph)) else $error("irq dropped by itself");
endmodule
bind eewa_ctrl eewa_ctrl_properties eewa_ctrl_properties_i (.sys_clk(sys_clk), .nrst(nrst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .flash_irq_in(flash_irq_in),
    .shared_irq(shared_irq));
`default_nettype wire

// *** bench/eewa_host_model.sv ***
// Purpose: AHB-Lite host issuing single word transfers
// Assumes: hready sampled settled before each edge
// Notes: Released address, protection and data lines show inverted values
`timescale 1ns/1ns
`default_nettype none
module eewa_host_model (
    input wire logic sys_clk,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [3:0] hprot,
    output logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hprot = 4'h3;
        hwdata = 32'h0;
    end
    task automatic edge_ready(output logic [31:0] q);
        logic r;
        do
        begin
            @(negedge sys_clk);
            r = hready;
            q = hrdata;
            @(posedge sys_clk);
        end
        while (r !== 1'b1);
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        input logic [3:0] p, output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        hprot <= p;
        edge_ready(q);
        hsel <= 1'b0;
        htrans <= 2'h0;
        haddr <= ~a;
        hprot <= ~p;
        hwdata <= d;
        edge_ready(q);
        hwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// *** bench/eewa_ctrl_tb_top.sv ***
// Purpose: Register level test of the EEPROM controller
// Assumes: Host model speaks AHB-Lite
// Notes: Program and erase times are package constants
`timescale 1ns/1ns
`default_nettype none
module eewa_ctrl_tb_top;
    logic sys_clk, nrst, flash_irq_in, hsel, hwrite, hready, hresp, shared_irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] hprot;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    eewa_ctrl eewa_ctrl_i (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
        .flash_irq_in(flash_irq_in), .shared_irq(shared_irq));
    eewa_host_model eewa_host_model_i (.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hprot(hprot), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata));
    initial sys_clk = 1'b0;
    always #4 sys_clk = ~sys_clk;
    task report_and_stop();
        $display("failures %0d checks %0d", failures, checks_done);
        if (failures == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            failures = failures + 1;
            report_and_stop();
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] p = 4'h3);
        logic [31:0] q;
        eewa_host_model_i.xfer(1'b1, {24'h0, a}, d, p, q);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [3:0] p = 4'h3);
        logic [31:0] q;
        eewa_host_model_i.xfer(1'b0, {24'h0, a}, 32'h0, p, q);
        check(q, exp);
    endtask
    task irq_is(input logic v);
        @(negedge sys_clk);
        check({31'h0, shared_irq}, {31'h0, v});
    endtask
    task wait_irq();
        int n;
        n = 0;
        while (shared_irq !== 1'b1 && n < 1200)
        begin
            @(negedge sys_clk);
            n++;
        end
        check({31'h0, shared_irq}, 32'h1);
    endtask
    initial
    begin
        nrst = 1'b0;
        flash_irq_in = 1'b0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        rd(eewa_pkg::OFS_SIZE, 32'h100);
        rd(eewa_pkg::OFS_STATUS, 32'h0);
        rd(8'h30, 32'h0);
        wr(eewa_pkg::OFS_IM, 32'h1);
        wr(eewa_pkg::OFS_ADDR, 32'h0);
        wr(eewa_pkg::OFS_WDATA, 32'h12345678);
        rd(eewa_pkg::OFS_STATUS, 32'h28);
        wait_irq();
        rd(eewa_pkg::OFS_MIS, 32'h1);
        rd(eewa_pkg::OFS_STATUS, 32'h0);
        wr(eewa_pkg::OFS_ICR, 32'h1);
        rd(eewa_pkg::OFS_RIS, 32'h0);
        irq_is(1'b0);
        wr(eewa_pkg::OFS_FLASH_IM, 32'h0);
        rd(eewa_pkg::OFS_IM, 32'h0);
        wr(eewa_pkg::OFS_WDATA, 32'h56789abc);
        repeat (140) @(posedge sys_clk);
        rd(eewa_pkg::OFS_RIS, 32'h1);
        rd(eewa_pkg::OFS_MIS, 32'h0);
        irq_is(1'b0);
        wr(eewa_pkg::OFS_FLASH_IM, 32'h4);
        irq_is(1'b1);
        rd(eewa_pkg::OFS_FLASH_IM, 32'h4);
        rd(eewa_pkg::OFS_IM, 32'h1);
        wr(eewa_pkg::OFS_ICR, 32'h1);
        flash_irq_in <= 1'b1;
        irq_is(1'b1);
        @(posedge sys_clk);
        flash_irq_in <= 1'b0;
        wr(eewa_pkg::OFS_ADDR, 32'h0);
        rd(eewa_pkg::OFS_RDATA, 32'h12345678);
        rd(eewa_pkg::OFS_RDATA, 32'h56789abc);
        wr(eewa_pkg::OFS_ADDR, 32'h2);
        wr(eewa_pkg::OFS_WDATA, 32'h0);
        rd(eewa_pkg::OFS_STATUS, 32'h1);
        rd(eewa_pkg::OFS_RDATA, 32'h0);
        rd(eewa_pkg::OFS_ADDR, 32'h2);
        wr(eewa_pkg::OFS_ADDR, 32'h0);
        wr(eewa_pkg::OFS_PROT, 32'h2);
        wr(eewa_pkg::OFS_WDATA, 32'h0, 4'h0);
        rd(eewa_pkg::OFS_STATUS, 32'h4);
        rd(eewa_pkg::OFS_RDATA, 32'h0, 4'h0);
        rd(eewa_pkg::OFS_RDATA, 32'h12345678);
        wr(eewa_pkg::OFS_PROT, 32'h1);
        wr(eewa_pkg::OFS_WDATA, 32'h0);
        rd(eewa_pkg::OFS_STATUS, 32'h4);
        rd(eewa_pkg::OFS_PROT, 32'h1);
        wr(eewa_pkg::OFS_CMD, 32'h1);
        rd(eewa_pkg::OFS_STATUS, 32'h30);
        wr(eewa_pkg::OFS_CMD, 32'h1);
        rd(eewa_pkg::OFS_STATUS, 32'h32);
        wait_irq();
        rd(eewa_pkg::OFS_RIS, 32'h1);
        rd(eewa_pkg::OFS_STATUS, 32'h2);
        rd(eewa_pkg::OFS_PROT, 32'h0);
        rd(eewa_pkg::OFS_RDATA, eewa_pkg::ERASED_WORD);
        rd(eewa_pkg::OFS_RDATA, eewa_pkg::ERASED_WORD);
        wr(eewa_pkg::OFS_WDATA, 32'h1, 4'h0);
        rd(eewa_pkg::OFS_STATUS, 32'h28);
        report_and_stop();
    end
endmodule
`default_nettype wire
